/* File: qrp_consts.svh */
/*
 constants for the quad regulator write port: bus address, byte fields,
 reset values and filter timing. assumes a link sampling clock of 12 ns.
*/
// Functional notes
// - only address byte 8'hCA (seven bits plus write zero) is recognised.
// - matching address with read bit set gets no acknowledge; frame ignored.
// - sub-address bits 7..4 select regulators 0..3; any combination allowed.
// - sub-address bits 1..0 give mode; bits 3..2 ignored.
// - data bit 7 enables (1) or shuts down (0) each selected regulator.
// - adjustable regulators take data bits 3..0 as code; bits 6..4 ignored.
// - fixed regulators take data bits 6..0 as a seven-bit code.
// - device acknowledges address, sub-address and data bytes in turn.
// - on data acknowledge, data and mode load selected holding latches.
// - repeated frames allowed without limit; latches keep latest valid data.
// - stop after valid data copies all latches to active settings at once.
// - stop during an incomplete own frame is ignored; no update applied.
// - pending data is applied on any later stop despite restarts elsewhere.
// - after own address acked on restart, stops ignored until frame done.
// - mode 00 pulse skip, 01 linear, 10 forced burst, 11 auto burst.
// - fixed code bits 6..2 give base voltage, bits 1..0 add fine steps.
// - low logic supply clears the port, forces adjustable codes full scale.
// - device holds data line low through each acknowledge clock high time.
`ifndef QRP_CONSTS_SVH
`define QRP_CONSTS_SVH

`define QRP_NREG         4
`define QRP_NADJ         2
`define QRP_ADDR_BYTE    8'hCA
`define QRP_SEL_MSB      7
`define QRP_MODE_MSB     1
`define QRP_EN_BIT       7
`define QRP_ADJ_CODE_MSB 3
`define QRP_FIX_CODE_MSB 6
`define QRP_SET_RST      10'h000
`define QRP_ADJ_FULL     7'h0F
`define QRP_BYTE_BITS    4'h8
`define QRP_LINK_NS      12
`define QRP_GLITCH_NS    50
`define QRP_GLITCH_CYC   ((`QRP_GLITCH_NS + `QRP_LINK_NS - 1) / `QRP_LINK_NS)

`endif

/* File: qrp_glitch.sv */
/*
 per-bit spike filter: output follows input only after it has differed
 for CYC consecutive clocks. assumes synchronised inputs.
*/
`timescale 1ns/1ns
module qrp_glitch #(
   parameter int WIDTH = 2,
   parameter int CYC   = 5,
   parameter logic [WIDTH-1:0] RST = '1
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             arst_n,
   // levels
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   localparam int CW = $clog2(CYC + 1);

   logic [WIDTH-1:0] q_q;
   logic [WIDTH-1:0] q_d;

   // -----------------------------------------------------------------
   // one filter per line
   // -----------------------------------------------------------------
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      logic [CW-1:0] cnt_q;
      logic [CW-1:0] cnt_d;
      always_comb begin
         cnt_d  = '0;
         q_d[i] = q_q[i];
         if (d[i] != q_q[i]) begin
            if (cnt_q == CW'(CYC - 1)) begin
               q_d[i] = d[i];
            end else begin
               cnt_d = cnt_q + CW'(1);
            end
         end
      end
      always_ff @(posedge clk or negedge arst_n) begin
         if (!arst_n) begin
            cnt_q  <= '0;
            q_q[i] <= RST[i];
         end else begin
            cnt_q  <= cnt_d;
            q_q[i] <= q_d[i];
         end
      end
   end

   assign q = q_q;
endmodule : qrp_glitch

/* File: qrp_master.sv */
/*
 two-wire bus master model that drives the write port's serial pins.
 assumes the bench resolves the data wire from sda_m and the port's drive.
*/
`timescale 1ns/1ns
module qrp_master #(
   parameter int Q = 15
) (
   // clock the bench steps on
   input  wire logic clk,
   // bus
   output logic      scl,
   output logic      sda_m,
   input  wire logic sda_w
);
   // ------------------------------------------------
   // bus phases, all changes at falling clk edges
   // ------------------------------------------------
   initial begin
      scl   = 1'b1;
      sda_m = 1'b1;
   end

   task automatic w(input int n);
      repeat (n) @(negedge clk);
   endtask : w

   // works from an idle bus and as a repeated start
   task automatic start();
      if (scl == 1'b0) begin
         sda_m = 1'b1;
         w(Q);
         scl = 1'b1;
         w(Q);
      end
      sda_m = 1'b0;
      w(Q);
      scl = 1'b0;
      w(Q);
   endtask : start

   task automatic stop();
      sda_m = 1'b0;
      w(Q);
      scl = 1'b1;
      w(Q);
      sda_m = 1'b1;
      w(Q);
   endtask : stop

   // ack must be low both early and late in the high phase
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic a1;
      for (int i = 7; i >= 0; i--) begin
         sda_m = b[i];
         w(Q);
         scl = 1'b1;
         w(2 * Q);
         scl = 1'b0;
         w(Q);
      end
      sda_m = 1'b1;
      w(Q);
      scl = 1'b1;
      w(Q);
      a1 = sda_w;
      w(Q);
      ack = ~a1 & ~sda_w;
      scl = 1'b0;
      w(Q);
   endtask : send_byte
endmodule : qrp_master

/* File: qrp_pkg.sv */
/*
 types shared by the quad regulator write port.
 assumes nothing beyond a SystemVerilog compiler.
*/
package qrp_pkg;

   // -----------------------------------------------------------------
   // regulator mode and setting
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      QRP_PULSE_SKIP,
      QRP_LINEAR,
      QRP_FORCED_BURST,
      QRP_AUTO_BURST
   } qrp_mode_t;

   typedef struct packed {
      logic       en;
      qrp_mode_t  mode;
      logic [6:0] code;
   } qrp_setting_t;

   // -----------------------------------------------------------------
   // serial frame states
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      QRP_IDLE,
      QRP_ADDR,
      QRP_ACK_ADDR,
      QRP_SUB,
      QRP_ACK_SUB,
      QRP_DATA,
      QRP_ACK_DATA,
      QRP_SKIP
   } qrp_state_t;

endpackage : qrp_pkg

/* File: qrp_port.sv */
/*
 write-only two-wire slave port of a quad regulator controller.
 assumes link_clk is a free-running sampling clock much faster than scl,
 and an external pull-up resolves sda from sda_o / sda_oe_n.
*/
`timescale 1ns/1ns
`include "qrp_consts.svh"
module qrp_port import qrp_pkg::*; #(
   parameter int GLITCH_CYC = `QRP_GLITCH_CYC
) (
   // system clock and reset
   input  wire logic   clk,
   input  wire logic   arst_n,
   // serial link
   input  wire logic   link_clk,
   input  wire logic   scl,
   input  wire logic   sda_i,
   output logic        sda_o,
   output logic        sda_oe_n,
   // supply monitor
   input  wire logic   logic_supply_low,
   // active regulator settings
   output qrp_setting_t [`QRP_NREG-1:0] settings_q
);
   localparam qrp_setting_t SET_RST = qrp_setting_t'(`QRP_SET_RST);

   // -----------------------------------------------------------------
   // link domain: line conditioning
   // -----------------------------------------------------------------
   logic [2:0] lines_s;
   logic [1:0] lines_f;
   logic       scl_f;
   logic       sda_f;
   logic       uv_l;
   logic       scl_p_q;
   logic       sda_p_q;

   qrp_sync #(.WIDTH(3)) u_link_sync (
      .clk    (link_clk),
      .arst_n (arst_n),
      .d      ({logic_supply_low, scl, sda_i}),
      .q      (lines_s)
   );

   // filter delays both lines alike, so start/stop order is kept
   qrp_glitch #(.WIDTH(2), .CYC(GLITCH_CYC), .RST(2'h3)) u_glitch (
      .clk    (link_clk),
      .arst_n (arst_n),
      .d      (lines_s[1:0]),
      .q      (lines_f)
   );

   assign uv_l  = lines_s[2];
   assign scl_f = lines_f[1];
   assign sda_f = lines_f[0];

   always_ff @(posedge link_clk or negedge arst_n) begin
      if (!arst_n) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_p_q <= scl_f;
         sda_p_q <= sda_f;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   assign scl_rise = scl_f & ~scl_p_q;
   assign scl_fall = ~scl_f & scl_p_q;
   assign start_c  = scl_f & scl_p_q & sda_p_q & ~sda_f;
   assign stop_c   = scl_f & scl_p_q & ~sda_p_q & sda_f;

   // -----------------------------------------------------------------
   // link domain: frame engine
   // -----------------------------------------------------------------
   qrp_state_t   state_q, state_d;
   logic [3:0]   bits_q, bits_d;
   logic [7:0]   shift_q, shift_d;
   logic [7:0]   sub_q, sub_d;
   logic         drv_n_q, drv_n_d;
   logic         busy_q, busy_d;
   logic         pend_q, pend_d;
   logic         tgl_q, tgl_d;
   logic         load;
   logic         rx;
   qrp_setting_t [`QRP_NREG-1:0] hold_q, hold_d;
   qrp_setting_t [`QRP_NREG-1:0] xfer_q, xfer_d;

   assign rx = (state_q == QRP_ADDR) || (state_q == QRP_SUB) ||
               (state_q == QRP_DATA);

   always_comb begin
      state_d = state_q;
      bits_d  = bits_q;
      shift_d = shift_q;
      sub_d   = sub_q;
      drv_n_d = drv_n_q;
      busy_d  = busy_q;
      pend_d  = pend_q;
      tgl_d   = tgl_q;
      xfer_d  = xfer_q;
      load    = 1'b0;
      if (uv_l) begin
         state_d = QRP_IDLE;
         bits_d  = '0;
         drv_n_d = 1'b1;
         busy_d  = 1'b0;
         pend_d  = 1'b0;
      end else if (start_c) begin
         state_d = QRP_ADDR;
         bits_d  = '0;
         drv_n_d = 1'b1;
         busy_d  = 1'b0;
      end else if (stop_c) begin
         state_d = QRP_IDLE;
         drv_n_d = 1'b1;
         // incomplete own frame keeps busy set, so the stop is dropped
         if (pend_q && !busy_q) begin
            xfer_d = hold_q;
            tgl_d  = ~tgl_q;
            pend_d = 1'b0;
         end
      end else if (scl_rise && rx && bits_q < `QRP_BYTE_BITS) begin
         shift_d = {shift_q[6:0], sda_f};
         bits_d  = bits_q + 4'h1;
      end else if (scl_fall) begin
         case (state_q)
            QRP_ADDR: begin
               if (bits_q == `QRP_BYTE_BITS) begin
                  if (shift_q == `QRP_ADDR_BYTE) begin
                     state_d = QRP_ACK_ADDR;
                     drv_n_d = 1'b0;
                     busy_d  = 1'b1;
                  end else begin
                     state_d = QRP_SKIP;
                  end
               end
            end
            QRP_ACK_ADDR: begin
               state_d = QRP_SUB;
               drv_n_d = 1'b1;
               bits_d  = '0;
            end
            QRP_SUB: begin
               if (bits_q == `QRP_BYTE_BITS) begin
                  state_d = QRP_ACK_SUB;
                  drv_n_d = 1'b0;
                  sub_d   = shift_q;
               end
            end
            QRP_ACK_SUB: begin
               state_d = QRP_DATA;
               drv_n_d = 1'b1;
               bits_d  = '0;
            end
            QRP_DATA: begin
               if (bits_q == `QRP_BYTE_BITS) begin
                  state_d = QRP_ACK_DATA;
                  drv_n_d = 1'b0;
               end
            end
            QRP_ACK_DATA: begin
               // further bytes of this frame get no acknowledge
               state_d = QRP_SKIP;
               drv_n_d = 1'b1;
               load    = 1'b1;
               busy_d  = 1'b0;
               pend_d  = 1'b1;
            end
            default: begin
            end
         endcase
      end
   end

   // holding latch per regulator; unselected ones keep their data
   for (genvar k = 0; k < `QRP_NREG; k++) begin : g_hold
      qrp_setting_t nv;
      always_comb begin
         nv.en   = shift_q[`QRP_EN_BIT];
         nv.mode = qrp_mode_t'(sub_q[`QRP_MODE_MSB:0]);
         if (k < `QRP_NADJ) begin
            nv.code = {3'h0, shift_q[`QRP_ADJ_CODE_MSB:0]};
         end else begin
            nv.code = shift_q[`QRP_FIX_CODE_MSB:0];
         end
      end
      assign hold_d[k] = uv_l ? SET_RST :
                         (load && sub_q[`QRP_SEL_MSB - k]) ? nv :
                         hold_q[k];
   end

   always_ff @(posedge link_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= QRP_IDLE;
         bits_q  <= '0;
         shift_q <= 8'h00;
         sub_q   <= 8'h00;
         drv_n_q <= 1'b1;
         busy_q  <= 1'b0;
         pend_q  <= 1'b0;
         tgl_q   <= 1'b0;
         xfer_q  <= {`QRP_NREG{SET_RST}};
         hold_q  <= {`QRP_NREG{SET_RST}};
      end else begin
         state_q <= state_d;
         bits_q  <= bits_d;
         shift_q <= shift_d;
         sub_q   <= sub_d;
         drv_n_q <= drv_n_d;
         busy_q  <= busy_d;
         pend_q  <= pend_d;
         tgl_q   <= tgl_d;
         xfer_q  <= xfer_d;
         hold_q  <= hold_d;
      end
   end

   // open drain: only ever pulls low
   assign sda_o    = 1'b0;
   assign sda_oe_n = drv_n_q;

   // -----------------------------------------------------------------
   // system domain: apply settings
   // -----------------------------------------------------------------
   // xfer_q only moves on an apply, a whole frame apart, so it is stable
   // from two sync stages before until long after the toggle arrives here
   logic [1:0] sys_s;
   logic       tgl_s;
   logic       uv_s;
   logic       seen_q;
   logic       apply;
   qrp_setting_t [`QRP_NREG-1:0] act_d;

   qrp_sync #(.WIDTH(2)) u_sys_sync (
      .clk    (clk),
      .arst_n (arst_n),
      .d      ({tgl_q, logic_supply_low}),
      .q      (sys_s)
   );
   assign tgl_s = sys_s[1];
   assign uv_s  = sys_s[0];
   assign apply = tgl_s ^ seen_q;

   for (genvar k = 0; k < `QRP_NREG; k++) begin : g_act
      qrp_setting_t uv_val;
      always_comb begin
         uv_val = SET_RST;
         if (k < `QRP_NADJ) begin
            uv_val.code = `QRP_ADJ_FULL;
         end
      end
      assign act_d[k] = uv_s ? uv_val :
                        apply ? xfer_q[k] : settings_q[k];
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         seen_q     <= 1'b0;
         settings_q <= {`QRP_NREG{SET_RST}};
      end else begin
         seen_q     <= tgl_s;
         settings_q <= act_d;
      end
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   sequence s_byte_done;
      scl_fall && bits_q == `QRP_BYTE_BITS && !uv_l && !start_c && !stop_c;
   endsequence

   sequence s_addr_ok;
      state_q == QRP_ADDR ##0 s_byte_done ##0 shift_q == `QRP_ADDR_BYTE;
   endsequence

   // ack driven while scl is high and no bus event: only a filtered
   // scl fall may release it, so each high cycle keeps it for the next
   sequence s_ack_high;
      scl_f && !sda_oe_n && !uv_l && !start_c && !stop_c;
   endsequence

   chk_addr_acked: assert property (
      @(posedge link_clk) disable iff (!arst_n)
      s_addr_ok |=> !sda_oe_n && busy_q)
      else $error("own address not acknowledged");

   chk_read_nacked: assert property (
      @(posedge link_clk) disable iff (!arst_n)
      state_q == QRP_ADDR ##0 s_byte_done ##0
      shift_q == (`QRP_ADDR_BYTE | 8'h01)
      |=> sda_oe_n && state_q == QRP_SKIP)
      else $error("read request was acknowledged");

   chk_ack_holds: assert property (
      @(posedge link_clk) disable iff (!arst_n)
      s_ack_high |=> !sda_oe_n)
      else $error("acknowledge released early");

   chk_ack_only: assert property (
      @(posedge link_clk) disable iff (!arst_n)
      !sda_oe_n |-> state_q inside {QRP_ACK_ADDR, QRP_ACK_SUB,
                                    QRP_ACK_DATA})
      else $error("data line driven outside acknowledge");

   chk_latch_load: assert property (
      @(posedge link_clk) disable iff (!arst_n)
      load && sub_q[`QRP_SEL_MSB] && !uv_l
      |=> hold_q[0].en == $past(shift_q[`QRP_EN_BIT]) &&
          hold_q[0].code == {3'h0, $past(shift_q[3:0])})
      else $error("selected holding latch not loaded");

   chk_unsel_keep: assert property (
      @(posedge link_clk) disable iff (!arst_n)
      load && !sub_q[`QRP_SEL_MSB - 3] && !uv_l
      |=> $stable(hold_q[3]))
      else $error("unselected latch changed");

   chk_stop_apply: assert property (
      @(posedge link_clk) disable iff (!arst_n)
      stop_c && pend_q && !busy_q && !uv_l
      |=> tgl_q != $past(tgl_q) && xfer_q == $past(hold_q))
      else $error("valid stop did not apply latches");

   // low supply outranks the stop and clears pending by itself
   chk_stop_ignored: assert property (
      @(posedge link_clk) disable iff (!arst_n)
      stop_c && busy_q && !uv_l
      |=> $stable(tgl_q) && pend_q == $past(pend_q))
      else $error("stop inside own frame was honoured");

   chk_sys_update: assert property (
      @(posedge clk) disable iff (!arst_n)
      $changed(tgl_q) && !logic_supply_low
      ##1 !logic_supply_low [*4]
      |-> ##[0:2] settings_q == xfer_q)
      else $error("active settings not updated");

   chk_uv_full: assert property (
      @(posedge clk) disable iff (!arst_n)
      uv_s |=> settings_q[0].code == `QRP_ADJ_FULL &&
               settings_q[1].code == `QRP_ADJ_FULL &&
               !settings_q[2].en)
      else $error("low supply did not force full scale");
endmodule : qrp_port

/* File: qrp_port_tb_top.sv */
/*
 self-checking bench for the quad regulator write port.
 assumes qrp_master as bus master and a pull-up on the data wire.
*/
`timescale 1ns/1ns
`include "qrp_consts.svh"
module qrp_port_tb_top import qrp_pkg::*;;
   // ------------------------------------------------
   // clocks, wires and instances
   // ------------------------------------------------
   logic                         clk;
   logic                         link_clk;
   logic                         arst_n;
   logic                         uv;
   logic                         scl;
   logic                         sda_m;
   logic                         sda_o;
   logic                         sda_oe_n;
   logic                         sda_w;
   qrp_setting_t [`QRP_NREG-1:0] set_w;
   logic [9:0]                   hold_e [4];
   logic [9:0]                   act_e [4];
   int                           err_total;
   int                           check_count;

   initial begin
      clk      = 1'b0;
      link_clk = 1'b0;
      uv       = 1'b0;
   end
   always #5 clk = ~clk;
   initial begin
      #3;
      forever #6 link_clk = ~link_clk;
   end
   // open drain: pull-up unless someone pulls low
   assign sda_w = sda_m & (sda_oe_n | sda_o);

   qrp_port #(.GLITCH_CYC(5)) dut_u (
      .clk(clk), .arst_n(arst_n), .link_clk(link_clk), .scl(scl),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
      .logic_supply_low(uv), .settings_q(set_w)
   );
   qrp_master #(.Q(15)) mst_u (
      .clk(clk), .scl(scl), .sda_m(sda_m), .sda_w(sda_w)
   );

   // ------------------------------------------------
   // shared tasks
   // ------------------------------------------------
   task automatic chk(input string what, input logic [9:0] seen,
                      input logic [9:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_sim

   task automatic do_reset();
      arst_n = 1'b0;
      repeat (6) @(negedge clk);
      arst_n = 1'b1;
      repeat (20) @(negedge clk);
      for (int i = 0; i < 4; i++) begin
         hold_e[i] = 10'h000;
         act_e[i]  = 10'h000;
      end
   endtask : do_reset

   task automatic xfer(input logic [7:0] b, input logic exp_ack);
      logic ack;
      mst_u.send_byte(b, ack);
      chk("ack", {9'h000, ack}, {9'h000, exp_ack});
   endtask : xfer

   // whole frame to this port; mirrors the holding latch load
   task automatic own(input logic [7:0] sub, input logic [7:0] data);
      mst_u.start();
      xfer(`QRP_ADDR_BYTE, 1'b1);
      xfer(sub, 1'b1);
      xfer(data, 1'b1);
      for (int i = 0; i < 4; i++) begin
         if (sub[7-i]) begin
            hold_e[i] = {data[7], sub[1:0],
                         (i < 2) ? {3'h0, data[3:0]} : data[6:0]};
         end
      end
   endtask : own

   // fixed wait covers filter lag plus the clock crossing
   task automatic stop_chk(input logic applied);
      mst_u.stop();
      if (applied) begin
         act_e = hold_e;
      end
      repeat (60) @(negedge clk);
      for (int i = 0; i < 4; i++) begin
         chk("setting", set_w[i], act_e[i]);
      end
   endtask : stop_chk

   // ------------------------------------------------
   // scenarios
   // ------------------------------------------------
   task automatic t_reset();
      for (int i = 0; i < 4; i++) begin
         chk("reset", set_w[i], 10'h000);
      end
      $display("test reset done");
   endtask : t_reset

   task automatic t_single();
      own(8'h8E, 8'hF7);
      stop_chk(1'b1);
      $display("test single done");
   endtask : t_single

   task automatic t_modes();
      logic [1:0] md;
      for (int m = 0; m < 4; m++) begin
         md = 2'(m);
         own({6'h0F, md}, 8'hBD - 8'(m));
         stop_chk(1'b1);
      end
      $display("test modes done");
   endtask : t_modes

   // later frame to one regulator wins; foreign frame before stop
   task automatic t_multi();
      own(8'hC0, 8'h8F);
      own(8'h41, 8'h03);
      mst_u.start();
      xfer(8'h90, 1'b0);
      xfer(8'h12, 1'b0);
      stop_chk(1'b1);
      $display("test multi done");
   endtask : t_multi

   task automatic t_refuse();
      for (int i = 1; i < 8; i++) begin
         mst_u.start();
         xfer(`QRP_ADDR_BYTE ^ (8'h01 << i), 1'b0);
         stop_chk(1'b0);
      end
      mst_u.start();
      xfer(8'hCB, 1'b0);
      xfer(8'h80, 1'b0);
      xfer(8'h81, 1'b0);
      stop_chk(1'b0);
      mst_u.start();
      xfer(`QRP_ADDR_BYTE, 1'b1);
      xfer(8'h80, 1'b1);
      stop_chk(1'b0);
      own(8'h80, 8'h85);
      xfer(8'h55, 1'b0);
      stop_chk(1'b1);
      $display("test refuse done");
   endtask : t_refuse

   task automatic t_restart();
      own(8'h10, 8'h9A);
      mst_u.start();
      xfer(`QRP_ADDR_BYTE, 1'b1);
      xfer(8'h20, 1'b1);
      stop_chk(1'b0);
      own(8'h20, 8'hA5);
      stop_chk(1'b1);
      $display("test restart done");
   endtask : t_restart

   task automatic t_uv();
      uv = 1'b1;
      repeat (10) @(negedge clk);
      for (int i = 0; i < 4; i++) begin
         chk("lockout", set_w[i], (i < 2) ? 10'h00F : 10'h000);
      end
      mst_u.start();
      xfer(`QRP_ADDR_BYTE, 1'b0);
      mst_u.stop();
      uv = 1'b0;
      do_reset();
      t_reset();
      $display("test lockout done");
   endtask : t_uv

   // ------------------------------------------------
   // main sequence and hang guard
   // ------------------------------------------------
   initial begin
      err_total   = 0;
      check_count = 0;
      do_reset();
      t_reset();
      t_single();
      t_modes();
      t_multi();
      t_refuse();
      t_restart();
      t_uv();
      end_sim();
   end

   initial begin
      #600_000;
      err_total++;
      end_sim();
   end
endmodule : qrp_port_tb_top

/* File: qrp_sync.sv */
/*
 two flip-flop level synchroniser, any width.
 assumes each bit is a level that holds for several destination clocks.
*/
`timescale 1ns/1ns
module qrp_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             arst_n,
   // levels
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // first stage feeds only the second
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;
endmodule : qrp_sync
